// ---- inc/rpdi_pkg.sv ----
`default_nettype none
package rpdi_pkg;
	localparam int          RPDI_DIBIT_W    = 2;
	localparam int          RPDI_NIB_W      = 4;
	localparam int          RPDI_SLOW_HOLD  = 10;
	localparam int          RPDI_WIN_BITS   = 10;
	localparam int          RPDI_ZERO_GAP   = 2;
	localparam logic [1:0]  RPDI_IDLE_DIBIT = 2'h0;
	localparam logic [9:0]  RPDI_WIN_IDLE   = 10'h3ff;

	typedef enum logic [1:0] {
		RPDI_ST_IDLE,
		RPDI_ST_WAIT,
		RPDI_ST_DATA,
		RPDI_ST_DRAIN
	} rpdi_state_e;
endpackage
`default_nettype wire

// ---- rtl/rpdi_sync.sv ----
`default_nettype none
module rpdi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/rpdi_phy.sv ----
`default_nettype none
// Function
// - both data paths are two bits wide, at 10 and 100 Mb/s.
// - each transmit di-bit is taken on every reference cycle with enable high at 100 Mb/s, every tenth cycle at 10.
// - transmit data is ignored while enable is low; idle is 00.
// - carrier sense rises as soon as carrier is seen, not waiting for a reference edge.
// - carrier is squelch at 10 Mb/s, two non-adjacent zeroes in ten bits at 100.
// - carrier sense falls only on a reference tick at a nibble boundary, never between a nibble's two di-bits.
// - leftover bits after carrier make carrier sense toggle per nibble half.
// - on false carrier, carrier sense stays high while carrier lasts.
// - receive data shows 00 after carrier sense rises until decoded data arrives.
// - receive data changes only on reference edges, two bits per cycle at 100 Mb/s, per ten cycles at 10.
// - receive data is 00 while carrier sense is low, except in the drain state, where leftover first di-bits show.
// - receive error is raised at least one reference period on an error detected while the state is not idle.
module rpdi_phy
	import rpdi_pkg::*;
#(
	parameter int HOLD_CYCLES = rpdi_pkg::RPDI_SLOW_HOLD
) (
	input  wire logic                              clk_sys,
	input  wire logic                              rst_b,
	input  wire logic                              reference_clock_input,
	input  wire logic                              rmii_tx_en,
	input  wire logic [rpdi_pkg::RPDI_DIBIT_W-1:0] rmii_txd,
	output var  logic [rpdi_pkg::RPDI_DIBIT_W-1:0] rmii_rxd,
	output var  logic                              rmii_crs_dv,
	output var  logic                              rmii_rx_er,
	input  wire logic                              speed_100,
	input  wire logic                              squelch_pass,
	input  wire logic                              rx_line_bit,
	input  wire logic                              rx_line_bit_valid,
	input  wire logic                              false_carrier,
	input  wire logic [rpdi_pkg::RPDI_NIB_W-1:0]   rx_nib,
	input  wire logic                              rx_nib_valid,
	output var  logic                              rx_nib_ready,
	input  wire logic                              rx_code_err,
	output var  logic [rpdi_pkg::RPDI_DIBIT_W-1:0] tx_dibit,
	output var  logic                              tx_dibit_valid
);
	localparam int                DIVW     = $clog2(HOLD_CYCLES);
	localparam logic [DIVW-1:0]   DIV_LAST = DIVW'(HOLD_CYCLES - 1);

	typedef struct packed {
		rpdi_state_e               state;
		logic                      ref_prev;
		logic [DIVW-1:0]           div;
		logic                      phase;
		logic [RPDI_NIB_W-1:0]     nib;
		logic                      nib_full;
		logic                      nib_ready;
		logic                      err_pend;
		logic [RPDI_WIN_BITS-1:0]  win;
		logic                      crs_dv;
		logic [RPDI_DIBIT_W-1:0]   rxd;
		logic                      rx_er;
		logic [RPDI_DIBIT_W-1:0]   tx_dibit;
		logic                      tx_valid;
	} rpdi_reg_s;

	rpdi_reg_s                 st_reg;
	rpdi_reg_s                 st_next;
	logic                      ref_s;
	logic                      tx_en_s;
	logic [RPDI_DIBIT_W-1:0]   txd_s;
	logic                      squelch_s;
	logic                      ref_rise;
	logic                      ref_fall;
	logic                      tick;
	logic                      tx_take;
	logic                      carrier;
	logic                      load;
	logic                      consume;

	rpdi_sync #(
		.W(RPDI_DIBIT_W + 3)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.d       ({reference_clock_input, rmii_tx_en, rmii_txd, squelch_pass}),
		.q       ({ref_s, tx_en_s, txd_s, squelch_s})
	);

	function automatic logic split_zeroes(input logic [RPDI_WIN_BITS-1:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < RPDI_WIN_BITS; i++)
			for (int j = i + RPDI_ZERO_GAP; j < RPDI_WIN_BITS; j++)
				if (!w[i] && !w[j])
					hit = 1'b1;
		return hit;
	endfunction

	assign ref_rise = ref_s && !st_reg.ref_prev;
	assign ref_fall = !ref_s && st_reg.ref_prev;
	// one di-bit slot per reference edge at 100, per ten edges at 10
	assign tick     = ref_rise && (speed_100 || st_reg.div == DIV_LAST);
	// mid-cycle sample keeps clear of the far side's launch edge
	assign tx_take  = ref_fall && (speed_100 || st_reg.div == '0) && tx_en_s;
	assign carrier  = speed_100 ? split_zeroes(st_reg.win) : squelch_s;

	always_comb
	begin
		st_next          = st_reg;
		load             = rx_nib_valid && st_reg.nib_ready;
		consume          = 1'b0;
		st_next.ref_prev = ref_s;
		st_next.tx_valid = 1'b0;
		if (ref_rise)
			st_next.div = (st_reg.div == DIV_LAST) ? '0 : DIVW'(st_reg.div + 1'b1);
		if (rx_line_bit_valid)
			st_next.win = {st_reg.win[RPDI_WIN_BITS-2:0], rx_line_bit};
		if (tx_take)
		begin
			st_next.tx_valid = 1'b1;
			st_next.tx_dibit = txd_s;
		end
		if (rx_code_err)
			st_next.err_pend = 1'b1;
		if (tick)
		begin
			st_next.rx_er    = st_reg.err_pend && st_reg.state != RPDI_ST_IDLE;
			st_next.err_pend = rx_code_err;
		end
		if (st_reg.state == RPDI_ST_IDLE)
		begin
			if (carrier)
			begin
				st_next.crs_dv = 1'b1;
				st_next.rxd    = RPDI_IDLE_DIBIT;
				st_next.phase  = 1'b0;
				st_next.state  = RPDI_ST_WAIT;
			end
		end
		else if (tick)
		begin
			unique case (st_reg.state)
				RPDI_ST_WAIT:
				begin
					if (!carrier)
					begin
						st_next.crs_dv = 1'b0;
						st_next.state  = RPDI_ST_IDLE;
					end
					else if (st_reg.nib_full)
					begin
						st_next.rxd   = st_reg.nib[1:0];
						st_next.phase = 1'b1;
						st_next.state = RPDI_ST_DATA;
					end
				end
				RPDI_ST_DATA:
				begin
					if (st_reg.phase)
					begin
						st_next.rxd   = st_reg.nib[3:2];
						st_next.phase = 1'b0;
						consume       = 1'b1;
					end
					else if (carrier)
					begin
						st_next.rxd   = st_reg.nib_full ? st_reg.nib[1:0] : RPDI_IDLE_DIBIT;
						st_next.phase = st_reg.nib_full;
					end
					else if (st_reg.nib_full && !false_carrier)
					begin
						st_next.crs_dv = 1'b0;
						st_next.rxd    = st_reg.nib[1:0];
						st_next.phase  = 1'b1;
						st_next.state  = RPDI_ST_DRAIN;
					end
					else
					begin
						st_next.crs_dv = 1'b0;
						st_next.rxd    = RPDI_IDLE_DIBIT;
						st_next.state  = RPDI_ST_IDLE;
					end
				end
				RPDI_ST_DRAIN:
				begin
					if (st_reg.phase)
					begin
						st_next.crs_dv = 1'b1;
						st_next.rxd    = st_reg.nib[3:2];
						st_next.phase  = 1'b0;
						consume        = 1'b1;
					end
					else if (st_reg.nib_full)
					begin
						st_next.crs_dv = 1'b0;
						st_next.rxd    = st_reg.nib[1:0];
						st_next.phase  = 1'b1;
					end
					else
					begin
						st_next.crs_dv = 1'b0;
						st_next.rxd    = RPDI_IDLE_DIBIT;
						st_next.state  = RPDI_ST_IDLE;
					end
				end
				default:
				begin
					st_next.state = RPDI_ST_IDLE;
				end
			endcase
		end
		if (load)
			st_next.nib = rx_nib;
		st_next.nib_full  = load || (st_reg.nib_full && !consume);
		st_next.nib_ready = !st_next.nib_full;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg           <= '0;
			st_reg.state     <= RPDI_ST_IDLE;
			st_reg.win       <= RPDI_WIN_IDLE;
			st_reg.nib_ready <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign rmii_rxd       = st_reg.rxd;
	assign rmii_crs_dv    = st_reg.crs_dv;
	assign rmii_rx_er     = st_reg.rx_er;
	assign rx_nib_ready   = st_reg.nib_ready;
	assign tx_dibit       = st_reg.tx_dibit;
	assign tx_dibit_valid = st_reg.tx_valid;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// drain cycles show leftover data with carrier sense low
	idle_rxd_zero_a: assert property (!rmii_crs_dv && !$past(rmii_crs_dv)
		&& st_reg.state != RPDI_ST_DRAIN |-> rmii_rxd == RPDI_IDLE_DIBIT)
		else $error("receive data not idle while carrier sense low");
	rise_rxd_zero_a: assert property ($rose(rmii_crs_dv) && $past(st_reg.state) == RPDI_ST_IDLE
		|-> rmii_rxd == RPDI_IDLE_DIBIT)
		else $error("receive data not 00 at carrier sense rise");
	carrier_rise_fast_a: assert property (st_reg.state == RPDI_ST_IDLE && carrier
		|=> rmii_crs_dv)
		else $error("carrier sense late after carrier");
	rise_needs_carrier_a: assert property ($rose(rmii_crs_dv) && $past(st_reg.state) == RPDI_ST_IDLE
		|-> $past(carrier))
		else $error("carrier sense rose without carrier");
	fall_on_boundary_a: assert property ($fell(rmii_crs_dv)
		|-> $past(tick) && !$past(st_reg.phase))
		else $error("carrier sense fell off nibble boundary");
	drain_toggle_a: assert property (st_reg.state == RPDI_ST_DRAIN && tick && st_reg.phase
		|=> rmii_crs_dv ##1 rmii_crs_dv)
		else $error("carrier sense not raised on second di-bit");
	false_hold_a: assert property (false_carrier && carrier && rmii_crs_dv
		&& st_reg.state != RPDI_ST_DRAIN |=> rmii_crs_dv)
		else $error("carrier sense dropped during false carrier");
	rxd_on_edge_a: assert property ($changed(rmii_rxd) |-> $past(tick))
		else $error("receive data changed off a reference edge");
	tx_take_a: assert property (tx_take |=> tx_dibit_valid && tx_dibit == $past(txd_s))
		else $error("transmit di-bit not taken");
	tx_ignore_a: assert property (!tx_en_s && !$past(tx_en_s) |=> !tx_dibit_valid)
		else $error("transmit di-bit taken with enable low");
	rx_err_flag_a: assert property (tick && st_reg.err_pend && st_reg.state != RPDI_ST_IDLE
		|=> rmii_rx_er)
		else $error("receive error not raised");
	rx_err_hold_a: assert property (rmii_rx_er && !tick |=> rmii_rx_er)
		else $error("receive error shorter than one reference period");
	slow_hold_a: assert property (!speed_100 && $past(!speed_100) && $changed(rmii_rxd)
		|-> $past(st_reg.div) == DIV_LAST)
		else $error("slow di-bit not held ten reference cycles");

	frame_cover_c: cover property (st_reg.state == RPDI_ST_DATA && !carrier);
	drain_cover_c: cover property (st_reg.state == RPDI_ST_DRAIN ##1 rmii_crs_dv);
	false_cover_c: cover property (false_carrier && rmii_crs_dv);
	tx_cover_c: cover property (tx_dibit_valid);
endmodule
`default_nettype wire

// ---- bench/rpdi_mac_model.sv ----
`default_nettype none
module rpdi_mac_model (
	output var logic       ref_clk,
	output var logic       tx_en,
	output var logic [1:0] txd
);
	timeunit 1ns;
	timeprecision 1ps;
	// free-running reference, phase kept off the system clock edges
	initial
	begin
		ref_clk = 1'b0;
		#3;
		forever #80 ref_clk = ~ref_clk;
	end
	initial
	begin
		tx_en = 1'b0;
		txd   = 2'h3;
	end
	// each di-bit is held for hold reference cycles, changed on rising edges only
	task automatic send(input logic [15:0] bits, input int n, input int hold);
		for (int i = 0; i < n * hold; i++)
		begin
			@(posedge ref_clk);
			tx_en <= 1'b1;
			txd   <= bits[2 * (i / hold) +: 2];
		end
		@(posedge ref_clk);
		tx_en <= 1'b0;
		txd   <= ~bits[2 * (n - 1) +: 2];
	endtask
endmodule
`default_nettype wire

// ---- bench/tb_rmii_phy_data_interface.sv ----
`default_nettype none
module tb_rmii_phy_data_interface;
	import rpdi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 2;
	logic       clk_sys, rst_b, ref_clk, tx_en, speed_100, squelch_pass, false_carrier;
	logic       rx_line_bit, rx_line_bit_valid, rx_nib_valid, rx_code_err;
	logic       crs_dv, rx_er, rx_nib_ready, tx_dibit_valid;
	logic [1:0] txd, rxd, tx_dibit;
	logic [3:0] rx_nib;
	logic [1:0] txq[$];
	int         err_count, checked;

	rpdi_phy #(.HOLD_CYCLES(HOLD)) i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .reference_clock_input(ref_clk),
		.rmii_tx_en(tx_en), .rmii_txd(txd), .rmii_rxd(rxd), .rmii_crs_dv(crs_dv),
		.rmii_rx_er(rx_er), .speed_100(speed_100), .squelch_pass(squelch_pass),
		.rx_line_bit(rx_line_bit), .rx_line_bit_valid(rx_line_bit_valid),
		.false_carrier(false_carrier), .rx_nib(rx_nib), .rx_nib_valid(rx_nib_valid),
		.rx_nib_ready(rx_nib_ready), .rx_code_err(rx_code_err), .tx_dibit(tx_dibit),
		.tx_dibit_valid(tx_dibit_valid)
	);
	rpdi_mac_model i_mac (.ref_clk(ref_clk), .tx_en(tx_en), .txd(txd));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
		if (tx_dibit_valid === 1'b1)
			txq.push_back(tx_dibit);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task fail_out;
		chk(8'h0, 8'h1);
		wrap_up;
	endtask

	task automatic wait_crs(input logic v, input int lim);
		for (int i = 0; i <= lim; i++)
		begin
			@(negedge clk_sys);
			if (crs_dv === v)
				return;
		end
		fail_out;
	endtask

	// sample link outputs mid reference cycle, where they are settled
	task automatic slot(output logic [3:0] s);
		@(negedge ref_clk);
		s = {rx_er, crs_dv, rxd};
	endtask

	task automatic line(input logic [9:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk_sys);
			rx_line_bit       = b[i];
			rx_line_bit_valid = 1'b1;
		end
		@(negedge clk_sys);
		rx_line_bit_valid = 1'b0;
	endtask

	task automatic give(input logic [3:0] n);
		int i;
		@(negedge clk_sys);
		rx_nib       = n;
		rx_nib_valid = 1'b1;
		for (i = 0; i < 400 && rx_nib_ready !== 1'b1; i++)
			@(negedge clk_sys);
		if (i == 400)
			fail_out;
		@(negedge clk_sys);
		rx_nib_valid = 1'b0;
	endtask

	task automatic tx_run(input logic sp, input logic [7:0] bits, input int n, input int hold);
		@(negedge clk_sys);
		speed_100 = sp;
		txq.delete();
		i_mac.send({8'h0, bits}, n, hold);
		repeat (3) @(posedge ref_clk);
		chk(8'(txq.size()), 8'(n));
		for (int i = 0; i < n && i < txq.size(); i++)
			chk(txq[i], bits[2 * i +: 2]);
	endtask

	task automatic rx_run;
		logic [3:0] s;
		logic       er;
		line(10'h002, 3);
		wait_crs(1'b1, 6);
		slot(s);
		chk(s[1:0], 2'h0);
		give(4'hB);
		@(negedge clk_sys) rx_code_err = 1'b1;
		@(negedge clk_sys) rx_code_err = 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			slot(s);
			if (s[1:0] !== 2'h0)
				break;
		end
		chk(s[2:0], 3'b111);
		er = s[3];
		line(10'h3ff, 10);
		slot(s);
		chk(s[2:0], 3'b110);
		chk(er | s[3], 1'b1);
		give(4'h7);
		slot(s);
		chk(s[2:0], 3'b011);
		slot(s);
		chk(s[2:0], 3'b101);
		slot(s);
		chk(s[2:0], 3'b000);
	endtask

	task automatic sq_run;
		logic [3:0] s;
		@(negedge clk_sys);
		squelch_pass  = 1'b1;
		false_carrier = 1'b1;
		wait_crs(1'b1, 8);
		give(4'h9);
		for (int i = 0; i < 8; i++)
		begin
			slot(s);
			if (s[1:0] !== 2'h0)
				break;
		end
		chk(s[2:0], 3'b101);
		slot(s);
		chk(s[2:0], 3'b101);
		slot(s);
		chk(s[2:0], 3'b110);
		repeat (4)
		begin
			slot(s);
			chk(s[2], 1'b1);
		end
		@(negedge clk_sys);
		squelch_pass = 1'b0;
		wait_crs(1'b0, 400);
		repeat (4)
		begin
			slot(s);
			chk(s[2], 1'b0);
		end
	endtask

	initial
	begin
		{rst_b, squelch_pass, false_carrier, rx_line_bit, rx_line_bit_valid} = '0;
		{rx_nib_valid, rx_code_err, rx_nib} = '0;
		speed_100 = 1'b1;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		tx_run(1'b1, 8'h36, 4, 1);
		rx_run;
		tx_run(1'b0, 8'h07, 2, HOLD);
		sq_run;
		wrap_up;
	end
endmodule
`default_nettype wire
